// ==== rtl/flash_protection_logic.sv ====
// Protection controller for program flash, data memory and option bytes.
// Assumes one core clock; the debug request port is already in this domain.
// What this block does
// - Memory writes from software are blocked until an unlock key sequence, and relocked later.
// - A boot code region of up to 128 Kbytes, sized by option bytes, cannot be overwritten by software.
// - Boot region option bytes change only through the debug port; software attempts are ignored.
// - The boot region starts at address zero and grows in 512-byte steps from a byte pair.
// - Read-out protection is on when the lock option byte holds its active value.
// - While read-out protection is on, debug reads and writes of all memories are refused, except a write of the lock byte to another value.
// - Read-out protection holds in every mode, with no bypass path.
// - Removing read-out protection first runs a global erase of program and data memory.
// - The bootloader option is valid only when its two bytes are complements.
`timescale 1ns/1ps
module flash_protection_logic #(
  parameter logic [7:0] PROG_KEY_FIRST = 8'h5a,
  parameter logic [7:0] PROG_KEY_SECOND = 8'ha5,
  parameter logic [7:0] DATA_KEY_FIRST = 8'ha5,
  parameter logic [7:0] DATA_KEY_SECOND = 8'h5a
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Software memory write requests
  input wire logic cpu_wr_req,
  input wire logic [1:0] cpu_wr_space,
  input wire logic [16:0] cpu_wr_addr,
  input wire logic [7:0] cpu_wr_data,
  output logic cpu_wr_ok,
  output logic cpu_wr_blocked,
  // Debug port requests
  input wire logic dbg_req,
  input wire logic dbg_we,
  input wire logic [1:0] dbg_space,
  input wire logic [16:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  output logic dbg_mem_go,
  output logic dbg_opt_ack,
  output logic [7:0] dbg_opt_rdata,
  output logic dbg_refused,
  // Flash controller erase handshake
  output logic erase_req,
  input wire logic erase_done,
  // Option state
  output logic readout_lock,
  output logic bootloader_option_valid,
  output logic [16:0] boot_area_limit
);
  typedef enum {ST_IDLE, ST_ERASE, ST_COMMIT} erase_state_t;

  opt_if opt ();

  erase_state_t state_q;

  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  logic [7:0] ctrl_two_inv_q;

  logic wr_blocked_q;
  logic prog_unlocked;
  logic data_unlocked;

  logic [7:0] pend_data_q;
  logic opt_rd_pend_q;
  logic [7:0] rdata_d;

  logic lock_on;
  logic boot_valid;
  logic [16:0] boot_limit;
  logic opt_sw_en;

  logic status_wr;
  logic status_rd;

  logic cpu_in_boot;
  logic cpu_ok_d;
  logic dbg_opt_wr;
  logic dbg_opt_take;
  logic dbg_lock_removal;
  logic cpu_opt_wr;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_pair(input logic [7:0] a, input logic [7:0] b);
    return a == ~b;
  endfunction

  function automatic logic [16:0] steps_to_bytes(input logic [7:0] steps);
    return {steps, 9'h000};
  endfunction

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  option_store u_opt (
    .core_clk(core_clk),
    .resetn(resetn),
    .opt(opt.store)
  );

  unlock_key_seq #(
    .KEY_FIRST(PROG_KEY_FIRST),
    .KEY_SECOND(PROG_KEY_SECOND)
  ) u_prog_key (
    .core_clk(core_clk),
    .resetn(resetn),
    .key_wr(reg_wr && reg_addr == flash_prot_pkg::OFF_PROG_KEY),
    .key_data(reg_wdata),
    .relock(status_wr && !reg_wdata[flash_prot_pkg::STAT_PROG_UNLOCKED]),
    .unlocked_q(prog_unlocked)
  );

  unlock_key_seq #(
    .KEY_FIRST(DATA_KEY_FIRST),
    .KEY_SECOND(DATA_KEY_SECOND)
  ) u_data_key (
    .core_clk(core_clk),
    .resetn(resetn),
    .key_wr(reg_wr && reg_addr == flash_prot_pkg::OFF_DATA_KEY),
    .key_data(reg_wdata),
    .relock(status_wr && !reg_wdata[flash_prot_pkg::STAT_DATA_UNLOCKED]),
    .unlocked_q(data_unlocked)
  );

  // ---------------------------------------------------------------
  // Option decode
  // ---------------------------------------------------------------
  // Lock is read from the live option byte; no mode input exists to mask it
  assign lock_on = opt.lock_byte == flash_prot_pkg::LOCK_ACTIVE;
  assign boot_valid = is_pair(opt.boot_size, opt.boot_size_inv);
  // An invalid size pair fails safe: every address below 0x1ffff is guarded, so only the top byte of the 128 Kbyte window is open
  assign boot_limit = boot_valid ? steps_to_bytes(opt.boot_size)
                                 : flash_prot_pkg::BOOT_MAX_BYTES;
  assign opt_sw_en = ctrl_two_q[flash_prot_pkg::CTRL_TWO_OPT_EN]
                     && is_pair(ctrl_two_q, ctrl_two_inv_q);
  assign status_wr = reg_wr && reg_addr == flash_prot_pkg::OFF_STATUS;
  assign status_rd = reg_rd && reg_addr == flash_prot_pkg::OFF_STATUS;

  // ---------------------------------------------------------------
  // Software write gate
  // ---------------------------------------------------------------
  assign cpu_in_boot = cpu_wr_addr < boot_limit;

  always_comb begin
    cpu_ok_d = 1'b0;
    case (cpu_wr_space)
      flash_prot_pkg::SPACE_PROG: cpu_ok_d = prog_unlocked && !cpu_in_boot;
      flash_prot_pkg::SPACE_DATA: cpu_ok_d = data_unlocked;
      default: cpu_ok_d = 1'b0;
    endcase
  end

  // Software may only touch the bootloader pair; boot size bytes never
  assign cpu_opt_wr = cpu_wr_req && cpu_wr_space == flash_prot_pkg::SPACE_OPT
                      && data_unlocked && opt_sw_en && state_q == ST_IDLE && !dbg_opt_take
                      && (cpu_wr_addr[2:0] == flash_prot_pkg::OPT_BL
                          || cpu_wr_addr[2:0] == flash_prot_pkg::OPT_BL_INV);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cpu_wr_ok <= 1'b0;
      cpu_wr_blocked <= 1'b0;
    end else begin
      cpu_wr_ok <= cpu_wr_req && (cpu_ok_d || cpu_opt_wr);
      cpu_wr_blocked <= cpu_wr_req && !(cpu_ok_d || cpu_opt_wr);
    end
  end

  // ---------------------------------------------------------------
  // Debug gate
  // ---------------------------------------------------------------
  assign dbg_opt_wr = dbg_req && dbg_we && dbg_space == flash_prot_pkg::SPACE_OPT;
  assign dbg_opt_take = dbg_opt_wr && !lock_on && state_q == ST_IDLE;
  // Only a write of the lock byte to another value may pass while locked
  assign dbg_lock_removal = dbg_opt_wr && lock_on
                            && dbg_addr[2:0] == flash_prot_pkg::OPT_LOCK
                            && dbg_wdata != flash_prot_pkg::LOCK_ACTIVE;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dbg_mem_go <= 1'b0;
      dbg_refused <= 1'b0;
    end else begin
      dbg_mem_go <= dbg_req && !lock_on && state_q == ST_IDLE
                    && dbg_space != flash_prot_pkg::SPACE_OPT;
      dbg_refused <= dbg_req && (state_q != ST_IDLE
                     || (lock_on && !dbg_lock_removal));
    end
  end

  // Option reads come back one cycle later from the store's read register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      opt_rd_pend_q <= 1'b0;
    end else begin
      opt_rd_pend_q <= dbg_req && !dbg_we && dbg_space == flash_prot_pkg::SPACE_OPT
                       && !lock_on && state_q == ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dbg_opt_ack <= 1'b0;
      dbg_opt_rdata <= 8'h00;
    end else begin
      dbg_opt_ack <= opt_rd_pend_q || (state_q == ST_COMMIT)
                     || dbg_opt_take;
      dbg_opt_rdata <= opt_rd_pend_q ? opt.rd_data : 8'h00;
    end
  end

  assign opt.rd_idx = dbg_addr[2:0];

  // ---------------------------------------------------------------
  // Option writes and global erase
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (dbg_lock_removal) state_q <= ST_ERASE;
        ST_ERASE: if (erase_done) state_q <= ST_COMMIT;
        ST_COMMIT: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pend_data_q <= 8'h00;
    end else if (state_q == ST_IDLE && dbg_lock_removal) begin
      pend_data_q <= dbg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      erase_req <= 1'b0;
    end else begin
      erase_req <= (state_q == ST_IDLE && dbg_lock_removal)
                   || (state_q == ST_ERASE && !erase_done);
    end
  end

  // A lock removal rewrites the lock byte only after the erase has completed
  always_comb begin
    opt.wr = 1'b0;
    opt.wr_idx = dbg_addr[2:0];
    opt.wr_data = dbg_wdata;
    if (state_q == ST_COMMIT) begin
      opt.wr = 1'b1;
      opt.wr_idx = flash_prot_pkg::OPT_LOCK;
      opt.wr_data = pend_data_q;
    end else if (dbg_opt_take) begin
      opt.wr = 1'b1;
    end else if (cpu_opt_wr) begin
      opt.wr = 1'b1;
      opt.wr_idx = cpu_wr_addr[2:0];
      opt.wr_data = cpu_wr_data;
    end
  end

  // ---------------------------------------------------------------
  // Option state outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      readout_lock <= 1'b0;
      bootloader_option_valid <= 1'b0;
      boot_area_limit <= 17'h00000;
    end else begin
      readout_lock <= lock_on;
      bootloader_option_valid <= is_pair(opt.bl_byte, opt.bl_byte_inv);
      boot_area_limit <= boot_limit;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_one_q <= flash_prot_pkg::RST_CTRL_ONE;
      ctrl_two_q <= flash_prot_pkg::RST_CTRL_TWO;
      ctrl_two_inv_q <= flash_prot_pkg::RST_CTRL_TWO_INV;
    end else if (reg_wr) begin
      if (reg_addr == flash_prot_pkg::OFF_CTRL_ONE) ctrl_one_q <= reg_wdata;
      if (reg_addr == flash_prot_pkg::OFF_CTRL_TWO) ctrl_two_q <= reg_wdata;
      if (reg_addr == flash_prot_pkg::OFF_CTRL_TWO_INV) ctrl_two_inv_q <= reg_wdata;
    end
  end

  // Sticky block flag: a new block wins over the read that clears it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_blocked_q <= 1'b0;
    end else if (cpu_wr_req && !(cpu_ok_d || cpu_opt_wr)) begin
      wr_blocked_q <= 1'b1;
    end else if (status_rd) begin
      wr_blocked_q <= 1'b0;
    end
  end

  // Protection bytes mirror the option store; writes here are ignored
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      flash_prot_pkg::OFF_CTRL_ONE: rdata_d = ctrl_one_q;
      flash_prot_pkg::OFF_CTRL_TWO: rdata_d = ctrl_two_q;
      flash_prot_pkg::OFF_CTRL_TWO_INV: rdata_d = ctrl_two_inv_q;
      flash_prot_pkg::OFF_PROT: rdata_d = opt.boot_size;
      flash_prot_pkg::OFF_PROT_INV: rdata_d = opt.boot_size_inv;
      flash_prot_pkg::OFF_STATUS: begin
        rdata_d = flash_prot_pkg::RST_STATUS;
        rdata_d[flash_prot_pkg::STAT_WR_BLOCKED] = wr_blocked_q;
        rdata_d[flash_prot_pkg::STAT_PROG_UNLOCKED] = prog_unlocked;
        rdata_d[flash_prot_pkg::STAT_DATA_UNLOCKED] = data_unlocked;
        rdata_d[flash_prot_pkg::STAT_ERASING] = state_q != ST_IDLE;
      end
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // flash_protection_logic

// ==== include/flash_prot_pkg.sv ====
// Constants shared by the flash protection logic and its option store.
// Assumes one core clock; all offsets are byte addresses on the register port.
package flash_prot_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFF_CTRL_ONE = 16'h505a;
  localparam logic [15:0] OFF_CTRL_TWO = 16'h505b;
  localparam logic [15:0] OFF_CTRL_TWO_INV = 16'h505c;
  localparam logic [15:0] OFF_PROT = 16'h505d;
  localparam logic [15:0] OFF_PROT_INV = 16'h505e;
  localparam logic [15:0] OFF_STATUS = 16'h505f;
  localparam logic [15:0] OFF_PROG_KEY = 16'h5062;
  localparam logic [15:0] OFF_DATA_KEY = 16'h5064;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO_INV = 8'hff;
  localparam logic [7:0] RST_STATUS = 8'h40;
  localparam logic [7:0] RST_LOCK_OPT = 8'h00;
  localparam logic [7:0] RST_BOOT_SIZE = 8'h00;
  localparam logic [7:0] RST_BOOT_SIZE_INV = 8'hff;
  localparam logic [7:0] RST_BL_OPT = 8'h00;
  localparam logic [7:0] RST_BL_OPT_INV = 8'hff;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STAT_WR_BLOCKED = 0;
  localparam int STAT_PROG_UNLOCKED = 1;
  localparam int STAT_DATA_UNLOCKED = 3;
  localparam int STAT_ERASING = 5;
  localparam int CTRL_TWO_OPT_EN = 7;
  // ---------------------------------------------------------------
  // Option byte indices and values
  // ---------------------------------------------------------------
  localparam logic [2:0] OPT_LOCK = 3'h0;
  localparam logic [2:0] OPT_BOOT_SIZE = 3'h1;
  localparam logic [2:0] OPT_BOOT_SIZE_INV = 3'h2;
  localparam logic [2:0] OPT_BL = 3'h3;
  localparam logic [2:0] OPT_BL_INV = 3'h4;
  localparam logic [7:0] LOCK_ACTIVE = 8'haa;
  localparam int BOOT_STEP_SHIFT = 9;
  localparam logic [16:0] BOOT_STEP_BYTES = 17'h00200;
  localparam logic [16:0] BOOT_MAX_BYTES = 17'h1ffff;
  // ---------------------------------------------------------------
  // Access spaces
  // ---------------------------------------------------------------
  localparam logic [1:0] SPACE_PROG = 2'h0;
  localparam logic [1:0] SPACE_DATA = 2'h1;
  localparam logic [1:0] SPACE_OPT = 2'h2;
endpackage

// ==== include/opt_if.sv ====
// Port between the protection controller and the option byte store.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface opt_if;
  logic wr;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [2:0] rd_idx;
  logic [7:0] rd_data;
  logic [7:0] lock_byte;
  logic [7:0] boot_size;
  logic [7:0] boot_size_inv;
  logic [7:0] bl_byte;
  logic [7:0] bl_byte_inv;
  modport store (
    input wr, wr_idx, wr_data, rd_idx,
    output rd_data, lock_byte, boot_size, boot_size_inv, bl_byte, bl_byte_inv
  );
  modport ctrl (
    output wr, wr_idx, wr_data, rd_idx,
    input rd_data, lock_byte, boot_size, boot_size_inv, bl_byte, bl_byte_inv
  );
endinterface

// ==== rtl/option_store.sv ====
// Option byte store: five bytes, registered read port, live copies out.
// Assumes writes arrive already checked by the protection controller.
`timescale 1ns/1ps
module option_store (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Controller side
  opt_if.store opt
);
  logic [7:0] mem_q [0:4];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mem_q[0] <= flash_prot_pkg::RST_LOCK_OPT;
      mem_q[1] <= flash_prot_pkg::RST_BOOT_SIZE;
      mem_q[2] <= flash_prot_pkg::RST_BOOT_SIZE_INV;
      mem_q[3] <= flash_prot_pkg::RST_BL_OPT;
      mem_q[4] <= flash_prot_pkg::RST_BL_OPT_INV;
    end else if (opt.wr && opt.wr_idx <= flash_prot_pkg::OPT_BL_INV) begin
      mem_q[opt.wr_idx] <= opt.wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      opt.rd_data <= 8'h00;
    end else if (opt.rd_idx <= flash_prot_pkg::OPT_BL_INV) begin
      opt.rd_data <= mem_q[opt.rd_idx];
    end else begin
      opt.rd_data <= 8'h00;
    end
  end

  assign opt.lock_byte = mem_q[0];
  assign opt.boot_size = mem_q[1];
  assign opt.boot_size_inv = mem_q[2];
  assign opt.bl_byte = mem_q[3];
  assign opt.bl_byte_inv = mem_q[4];
endmodule // option_store

// ==== rtl/unlock_key_seq.sv ====
// Two-key unlock sequencer for one memory space.
// Assumes key writes are single-cycle strobes from the register port.
`timescale 1ns/1ps
module unlock_key_seq #(
  parameter logic [7:0] KEY_FIRST = 8'h5a,
  parameter logic [7:0] KEY_SECOND = 8'ha5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Key writes and relock
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic relock,
  // State
  output logic unlocked_q
);
  logic first_seen_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      first_seen_q <= 1'b0;
    end else if (key_wr) begin
      first_seen_q <= !first_seen_q && key_data == KEY_FIRST;
    end
  end

  // A wrong key restarts the sequence rather than unlocking
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      unlocked_q <= 1'b0;
    end else if (key_wr && first_seen_q && key_data == KEY_SECOND) begin
      unlocked_q <= 1'b1;
    end else if (relock) begin
      unlocked_q <= 1'b0;
    end
  end
endmodule // unlock_key_seq

// ==== test/flash_protection_logic_assertions.sv ====
// Port-level checks of the flash protection logic.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
module flash_protection_logic_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Software writes
  input wire logic cpu_wr_req,
  input wire logic [1:0] cpu_wr_space,
  input wire logic [16:0] cpu_wr_addr,
  input wire logic cpu_wr_ok,
  input wire logic cpu_wr_blocked,
  // Debug port
  input wire logic dbg_req,
  input wire logic dbg_we,
  input wire logic [1:0] dbg_space,
  input wire logic [16:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  input wire logic dbg_mem_go,
  input wire logic dbg_opt_ack,
  input wire logic dbg_refused,
  // Erase and options
  input wire logic erase_req,
  input wire logic erase_done,
  input wire logic readout_lock,
  input wire logic [16:0] boot_area_limit
);
  // ------
  // Helpers
  // ------
  logic lock_clear;
  assign lock_clear = dbg_req && dbg_we && dbg_space == flash_prot_pkg::SPACE_OPT
    && dbg_addr[2:0] == flash_prot_pkg::OPT_LOCK && dbg_wdata != flash_prot_pkg::LOCK_ACTIVE;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ------
  // Assertions
  // ------
  AST_CPU_ONE_ANSWER: assert property (cpu_wr_req |=> cpu_wr_ok != cpu_wr_blocked)
    else $error("software write without exactly one answer");
  AST_BOOT_AREA_BLOCK: assert property (cpu_wr_req && cpu_wr_space == flash_prot_pkg::SPACE_PROG
    && cpu_wr_addr < boot_area_limit |=> cpu_wr_blocked)
    else $error("software write into boot area not blocked");
  AST_SW_BOOT_OPT: assert property (cpu_wr_req && cpu_wr_space == flash_prot_pkg::SPACE_OPT
    && cpu_wr_addr[2:0] <= flash_prot_pkg::OPT_BOOT_SIZE_INV |=> cpu_wr_blocked && !cpu_wr_ok)
    else $error("software changed a protected option byte");
  AST_BOOT_STEP: assert property (boot_area_limit[8:0] == 9'h000
    || boot_area_limit == flash_prot_pkg::BOOT_MAX_BYTES)
    else $error("boot area limit off the step grid");
  AST_LOCK_REFUSE: assert property (dbg_req && readout_lock && !lock_clear
    |=> dbg_refused && !dbg_mem_go && !dbg_opt_ack)
    else $error("debug access passed while locked");
  AST_OPEN_MEM: assert property (dbg_req && !readout_lock && !erase_req
    && dbg_space != flash_prot_pkg::SPACE_OPT |=> dbg_mem_go && !dbg_refused)
    else $error("unlocked debug memory access not passed");
  AST_ERASE_START: assert property (lock_clear && readout_lock && !erase_req |=> erase_req)
    else $error("lock removal did not start erase");
  AST_ERASE_HOLD: assert property (erase_req && !erase_done |=> erase_req)
    else $error("erase request dropped before done");
  AST_LOCK_DURING_ERASE: assert property (erase_req |-> readout_lock)
    else $error("lock released before erase finished");
  AST_LOCK_CAUSE: assert property ($changed(readout_lock)
    |-> dbg_opt_ack || $past(dbg_opt_ack))
    else $error("lock changed without option write");
  // ------
  // Cover
  // ------
  cover property (erase_req && erase_done);
  cover property (dbg_req && readout_lock ##1 dbg_refused);
  cover property (cpu_wr_req ##1 cpu_wr_ok);
  cover property (dbg_mem_go);
endmodule // flash_protection_logic_assertions

bind flash_protection_logic flash_protection_logic_assertions i_chk (
  .core_clk(core_clk), .resetn(resetn), .cpu_wr_req(cpu_wr_req),
  .cpu_wr_space(cpu_wr_space), .cpu_wr_addr(cpu_wr_addr), .cpu_wr_ok(cpu_wr_ok),
  .cpu_wr_blocked(cpu_wr_blocked), .dbg_req(dbg_req), .dbg_we(dbg_we),
  .dbg_space(dbg_space), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
  .dbg_mem_go(dbg_mem_go), .dbg_opt_ack(dbg_opt_ack), .dbg_refused(dbg_refused),
  .erase_req(erase_req), .erase_done(erase_done), .readout_lock(readout_lock),
  .boot_area_limit(boot_area_limit)
);

// ==== test/debug_host_model.sv ====
// Debug host model: turns bench commands into one-cycle debug requests.
// Assumes one bench command at a time.
`timescale 1ns/1ps
module debug_host_model (
  // Clock
  input wire logic core_clk,
  // Command from the bench
  input wire logic go,
  input wire logic we,
  input wire logic [1:0] sp,
  input wire logic [16:0] ad,
  input wire logic [7:0] wd,
  // Debug port
  output logic dbg_req,
  output logic dbg_we,
  output logic [1:0] dbg_space,
  output logic [16:0] dbg_addr,
  output logic [7:0] dbg_wdata
);
  initial {dbg_req, dbg_we, dbg_space, dbg_addr, dbg_wdata} = '0;
  // Idle lines toggle so stale fields never look valid
  always @(posedge core_clk) begin
    dbg_req <= go;
    if (go) {dbg_we, dbg_space, dbg_addr, dbg_wdata} <= {we, sp, ad, wd};
    else {dbg_we, dbg_space, dbg_addr, dbg_wdata} <= ~{dbg_we, dbg_space, dbg_addr, dbg_wdata};
  end
endmodule // debug_host_model

// ==== test/flash_protection_logic_test.sv ====
// Self-checking bench for the protection logic.
// Assumes package, interface and rtl are compiled first.
`timescale 1ns/1ps
module flash_protection_logic_test;
  logic core_clk, resetn, reg_wr, reg_rd, cpu_wr_req, erase_done, go, we;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, cpu_wr_data, wd, reg_rdata, dbg_wdata, dbg_opt_rdata, n;
  logic [1:0] cpu_wr_space, sp, dbg_space;
  logic [16:0] cpu_wr_addr, ad, dbg_addr, boot_area_limit, a, lim;
  logic cpu_wr_ok, cpu_wr_blocked, dbg_req, dbg_we, dbg_mem_go, dbg_opt_ack, dbg_refused;
  logic erase_req, readout_lock, bootloader_option_valid;
  logic [31:0] seed;
  int n_errors = 0, cmp_count = 0, cycles = 0;
  logic [15:0] offs [9] = '{16'h505a, 16'h505b, 16'h505c, 16'h505d, 16'h505e, 16'h505f,
    16'h5062, 16'h5064, 16'h5060};
  logic [7:0] rst [9] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h40, 8'h00, 8'h00, 8'h00};

  flash_protection_logic i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpu_wr_req, .cpu_wr_space, .cpu_wr_addr, .cpu_wr_data, .cpu_wr_ok,
    .cpu_wr_blocked, .dbg_req, .dbg_we, .dbg_space, .dbg_addr, .dbg_wdata, .dbg_mem_go,
    .dbg_opt_ack, .dbg_opt_rdata, .dbg_refused, .erase_req, .erase_done, .readout_lock,
    .bootloader_option_valid, .boot_area_limit);
  debug_host_model i_host (.core_clk, .go, .we, .sp, .ad, .wd, .dbg_req, .dbg_we,
    .dbg_space, .dbg_addr, .dbg_wdata);

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic prog_ok(input logic [16:0] addr, input logic [16:0] lim);
    return addr >= lim;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Tasks start and end 1 ns after an edge
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] ra, input logic [7:0] d);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, ra, d};
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [15:0] ra, input logic [7:0] exp);
    {reg_rd, reg_addr} <= {1'b1, ra};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic cpu(input logic [1:0] s, input logic [16:0] ca, input logic [7:0] d,
                     input logic ok);
    {cpu_wr_req, cpu_wr_space, cpu_wr_addr, cpu_wr_data} <= {1'b1, s, ca, d};
    @(posedge core_clk);
    cpu_wr_req <= 1'b0;
    #1 chk({cpu_wr_ok, cpu_wr_blocked}, {ok, !ok});
  endtask
  // Host model adds a cycle: answer seen two edges on
  task automatic dbg(input logic w, input logic [1:0] s, input logic [16:0] da,
                     input logic [7:0] d);
    {go, we, sp, ad, wd} <= {1'b1, w, s, da, d};
    @(posedge core_clk);
    go <= 1'b0;
    tick(1);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end

  // ------
  // Scenarios
  // ------
  initial begin
    {resetn, reg_wr, reg_rd, cpu_wr_req, erase_done, go, we, sp, cpu_wr_space} = '0;
    {reg_addr, reg_wdata, cpu_wr_data, wd, cpu_wr_addr, ad} = '0;
    seed = 32'h77650721;
    tick(20);
    resetn <= 1'b1;
    tick(2);
    foreach (offs[i]) rc(offs[i], rst[i]);
    chk({bootloader_option_valid, readout_lock, boot_area_limit}, 19'h40000);
    cpu(2'h0, 17'h10000, 8'h00, 1'b0);
    cpu(2'h1, 17'h00010, 8'h00, 1'b0);
    rc(16'h505f, 8'h41);
    rc(16'h505f, 8'h40);
    wr(16'h5062, 8'h5a);
    wr(16'h5062, 8'h00);
    wr(16'h5062, 8'ha5);
    rc(16'h505f, 8'h40);
    wr(16'h5062, 8'h5a);
    wr(16'h5062, 8'ha5);
    rc(16'h505f, 8'h42);
    seed = lfsr(seed);
    wr(16'h505a, seed[7:0]);
    rc(16'h505a, seed[7:0]);
    n = seed[15:8] | 8'h01;
    lim = {n, 9'h000};
    dbg(1'b1, 2'h2, 17'h1, n);
    chk(dbg_opt_ack, 1'b1);
    dbg(1'b1, 2'h2, 17'h2, ~n);
    tick(2);
    chk(boot_area_limit, lim);
    wr(16'h505d, ~n);
    rc(16'h505d, n);
    rc(16'h505e, ~n);
    dbg(1'b0, 2'h2, 17'h1, 8'h00);
    tick(1);
    chk({dbg_opt_ack, dbg_opt_rdata}, {1'b1, n});
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? lim - 17'h1 : (i == 1) ? lim : seed[16:0];
      cpu(2'h0, a, seed[31:24], prog_ok(a, lim));
      dbg(seed[20], {1'b0, seed[21]}, a, seed[31:24]);
      chk({dbg_mem_go, dbg_refused}, 2'b10);
    end
    dbg(1'b1, 2'h2, 17'h2, n);
    tick(2);
    chk(boot_area_limit, 17'h1ffff);
    cpu(2'h0, 17'h1fffe, 8'h00, 1'b0);
    cpu(2'h0, 17'h1ffff, 8'h00, 1'b1);
    wr(16'h5064, 8'ha5);
    wr(16'h5064, 8'h5a);
    wr(16'h505b, 8'h80);
    wr(16'h505c, 8'h7f);
    rc(16'h505f, 8'h4b);
    cpu(2'h1, 17'h00020, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++) cpu(2'h2, 17'(i), 8'h00, 1'b0);
    cpu(2'h2, 17'h3, 8'h3c, 1'b1);
    cpu(2'h2, 17'h4, 8'hc3, 1'b1);
    tick(2);
    chk(bootloader_option_valid, 1'b1);
    cpu(2'h2, 17'h4, 8'h3c, 1'b1);
    tick(2);
    chk(bootloader_option_valid, 1'b0);
    wr(16'h505f, 8'h00);
    cpu(2'h0, 17'h1ffff, 8'h00, 1'b0);
    dbg(1'b1, 2'h2, 17'h0, 8'haa);
    chk(dbg_opt_ack, 1'b1);
    tick(2);
    chk(readout_lock, 1'b1);
    for (int i = 0; i < 6; i++) begin
      dbg(i[0], 2'(i >> 1), 17'h0, 8'haa);
      chk({dbg_mem_go, dbg_opt_ack, dbg_refused}, 3'b001);
    end
    dbg(1'b1, 2'h2, 17'h0, 8'h00);
    // Erase held off five cycles
    for (int i = 0; i < 5; i++) begin
      chk({erase_req, readout_lock}, 2'b11);
      tick(1);
    end
    erase_done <= 1'b1;
    tick(1);
    erase_done <= 1'b0;
    chk(erase_req, 1'b0);
    tick(1);
    chk(dbg_opt_ack, 1'b1);
    tick(1);
    chk(readout_lock, 1'b0);
    dbg(1'b0, 2'h0, 17'h0, 8'h00);
    chk(dbg_mem_go, 1'b1);
    results();
  end
endmodule // flash_protection_logic_test
